// file: sbst_pkg.sv
// Constants, codes and state types shared by the scan-register logic.
package sbst_pkg;

	// ----------------------------------------------------------------
	// Register sizes
	// ----------------------------------------------------------------
	localparam int SBST_IR_W   = 3;
	localparam int SBST_ID_W   = 32;
	localparam int SBST_BND_LEN = 71;

	// ----------------------------------------------------------------
	// Instruction codes
	// ----------------------------------------------------------------
	localparam logic [SBST_IR_W-1:0] SBST_INS_EXTEST   = 3'h0;
	localparam logic [SBST_IR_W-1:0] SBST_INS_IDCODE   = 3'h1;
	localparam logic [SBST_IR_W-1:0] SBST_INS_HIZ_SAMP = 3'h2;
	localparam logic [SBST_IR_W-1:0] SBST_INS_SAMPLE   = 3'h4;
	localparam logic [SBST_IR_W-1:0] SBST_INS_BYPASS   = 3'h7;
	localparam logic [SBST_IR_W-1:0] SBST_IR_CAPTURE   = 3'h1;
	localparam logic [1:0]           SBST_IR_CAP_LOW   = 2'h1;
	localparam logic                 SBST_BYP_CAPTURE  = 1'b0;

	// ----------------------------------------------------------------
	// Identification word layout
	// ----------------------------------------------------------------
	localparam int SBST_ID_REV_LSB   = 29;
	localparam int SBST_ID_REV_W     = 3;
	localparam int SBST_ID_DEPTH_LSB = 24;
	localparam int SBST_ID_DEPTH_W   = 5;
	localparam int SBST_ID_TYPE_LSB  = 18;
	localparam int SBST_ID_TYPE_W    = 6;
	localparam int SBST_ID_PART_LSB  = 12;
	localparam int SBST_ID_PART_W    = 6;
	localparam int SBST_ID_MAKER_LSB = 1;
	localparam int SBST_ID_MAKER_W   = 11;
	localparam int SBST_ID_PRESENT   = 0;
	localparam logic SBST_ID_PRESENT_VAL = 1'b1;

	// ----------------------------------------------------------------
	// Boundary cell indices (cell n sits at index n-1)
	// ----------------------------------------------------------------
	localparam int SBST_CELL_CLOCK    = 0;
	localparam int SBST_CELL_ADV      = 6;
	localparam int SBST_CELL_SLEEP    = 18;
	localparam int SBST_CELL_ADDR0    = 36;
	localparam int SBST_CELL_ADDR1    = 37;
	localparam int SBST_CELL_INTERNAL = 70;

	// ----------------------------------------------------------------
	// Test state machine
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		SBST_TLR, SBST_RTI,
		SBST_SEL_DR, SBST_CAP_DR, SBST_SH_DR, SBST_EX1_DR,
		SBST_PAU_DR, SBST_EX2_DR, SBST_UPD_DR,
		SBST_SEL_IR, SBST_CAP_IR, SBST_SH_IR, SBST_EX1_IR,
		SBST_PAU_IR, SBST_EX2_IR, SBST_UPD_IR
	} sbst_tap_e;

endpackage : sbst_pkg

// file: sbst_sync.sv
// Two-flop level synchroniser with a constant synchronous reset value.
`timescale 1ns/1ns
`default_nettype none
module sbst_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk, // Destination clock.
	input  wire logic         rst, // Synchronous reset, active high.
	input  wire logic [W-1:0] d,   // Level from another domain.
	output logic      [W-1:0] q    // Synchronised level.
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sbst_sync_s;

	sbst_sync_s st_r;
	sbst_sync_s st_nxt;

	generate
		if (W < 1) begin : g_chk
			$error("sbst_sync width must be at least one");
		end
	endgenerate

	// The first stage feeds the second stage and nothing else.
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
		if (rst) begin
			st_nxt.s1 = RST_VAL;
			st_nxt.s2 = RST_VAL;
		end
	end

	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	assign q = st_r.s2;

endmodule : sbst_sync
`default_nettype wire

// file: sbst_tap_regs.sv
// Test access port: state machine, instruction, bypass, identity and pin scan chain.
`timescale 1ns/1ns
`default_nettype none
module sbst_tap_regs
	import sbst_pkg::*;
#(
	parameter logic                       WIDE_ORG    = 1'b1,
	parameter logic [SBST_ID_REV_W-1:0]   REV_CODE    = 3'h5,   // Arbitrary value.
	parameter logic [SBST_ID_DEPTH_W-1:0] DEPTH_CODE  = 5'h13,  // Arbitrary value.
	parameter logic [SBST_ID_TYPE_W-1:0]  TYPE_CODE   = 6'h2d,  // Arbitrary value.
	parameter logic [SBST_ID_PART_W-1:0]  PART_WIDE   = 6'h2a,  // Arbitrary value.
	parameter logic [SBST_ID_PART_W-1:0]  PART_NARROW = 6'h15,  // Arbitrary value.
	parameter logic [SBST_ID_MAKER_W-1:0] MAKER_CODE  = 11'h2c3 // Arbitrary value.
) (
	input  wire logic                              clk,          // Memory clock.
	input  wire logic                              rst,          // Sync reset, high.
	input  wire logic                              tck,          // Test clock.
	input  wire logic                              tms,          // Test mode select.
	input  wire logic                              tdi,          // Serial data in.
	output logic                                   tdo,          // Serial data out.
	output logic                                   tdo_oe,       // Drive enable of tdo.
	input  wire logic [sbst_pkg::SBST_BND_LEN-1:0] ring_in,      // Pin levels to scan.
	output logic      [sbst_pkg::SBST_BND_LEN-1:0] ring_hold,    // Preloaded cell values.
	output logic      [sbst_pkg::SBST_IR_W-1:0]    instr,        // Active instruction.
	output logic                                   mem_out_hiz   // Float memory outputs.
);
	import sbst_pkg::*;

	localparam logic [SBST_ID_W-1:0] ID_WORD = {REV_CODE, DEPTH_CODE, TYPE_CODE,
		(WIDE_ORG ? PART_WIDE : PART_NARROW), MAKER_CODE, SBST_ID_PRESENT_VAL};

	generate
		if ($bits(ID_WORD) != SBST_ID_W) begin : g_idchk
			$error("identity word width mismatch");
		end
		if (SBST_BND_LEN <= SBST_CELL_INTERNAL) begin : g_bndchk
			$error("pin scan chain too short for its cell map");
		end
	endgenerate

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		sbst_tap_e               tap;
		logic [SBST_IR_W-1:0]    ir_sh;
		logic [SBST_IR_W-1:0]    ir;
		logic                    byp;
		logic [SBST_ID_W-1:0]    id_sh;
		logic [SBST_BND_LEN-1:0] bnd_sh;
		logic [SBST_BND_LEN-1:0] hold;
		logic                    hiz;
	} sbst_state_s;

	sbst_state_s             st_r;
	sbst_state_s             st_nxt;
	logic                    tck_rst;
	logic [SBST_BND_LEN-1:0] ring_sync;
	logic                    sel_bnd;
	logic                    sel_id;

	// ----------------------------------------------------------------
	// Crossings
	// ----------------------------------------------------------------
	// The power-up reset is carried into the test clock so that the test
	// logic starts on the identity instruction without a TMS sequence.
	sbst_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
		.clk (tck),
		.rst (1'b0),
		.d   (rst),
		.q   (tck_rst)
	);

	// Pins change on the fast memory clock; a capture may see a pin in
	// transition, so the captured value of a moving pin is not repeatable.
	sbst_sync #(.W(SBST_BND_LEN), .RST_VAL('0)) u_ring_sync (
		.clk (tck),
		.rst (tck_rst),
		.d   (ring_in),
		.q   (ring_sync)
	);

	sbst_sync #(.W(1), .RST_VAL(1'b0)) u_hiz_sync (
		.clk (clk),
		.rst (rst),
		.d   (st_r.hiz),
		.q   (mem_out_hiz)
	);

	// ----------------------------------------------------------------
	// Test state machine step
	// ----------------------------------------------------------------
	function automatic sbst_tap_e tap_step(input sbst_tap_e cur, input logic m);
		sbst_tap_e nx;
		nx = cur;
		case (cur)
			SBST_TLR:    nx = m ? SBST_TLR    : SBST_RTI;
			SBST_RTI:    nx = m ? SBST_SEL_DR : SBST_RTI;
			SBST_SEL_DR: nx = m ? SBST_SEL_IR : SBST_CAP_DR;
			SBST_CAP_DR: nx = m ? SBST_EX1_DR : SBST_SH_DR;
			SBST_SH_DR:  nx = m ? SBST_EX1_DR : SBST_SH_DR;
			SBST_EX1_DR: nx = m ? SBST_UPD_DR : SBST_PAU_DR;
			SBST_PAU_DR: nx = m ? SBST_EX2_DR : SBST_PAU_DR;
			SBST_EX2_DR: nx = m ? SBST_UPD_DR : SBST_SH_DR;
			SBST_UPD_DR: nx = m ? SBST_SEL_DR : SBST_RTI;
			SBST_SEL_IR: nx = m ? SBST_TLR    : SBST_CAP_IR;
			SBST_CAP_IR: nx = m ? SBST_EX1_IR : SBST_SH_IR;
			SBST_SH_IR:  nx = m ? SBST_EX1_IR : SBST_SH_IR;
			SBST_EX1_IR: nx = m ? SBST_UPD_IR : SBST_PAU_IR;
			SBST_PAU_IR: nx = m ? SBST_EX2_IR : SBST_PAU_IR;
			SBST_EX2_IR: nx = m ? SBST_UPD_IR : SBST_SH_IR;
			SBST_UPD_IR: nx = m ? SBST_SEL_DR : SBST_RTI;
			default:     nx = SBST_TLR;
		endcase
		return nx;
	endfunction : tap_step

	// ----------------------------------------------------------------
	// Register path selection
	// ----------------------------------------------------------------
	// Reserved codes fall back to the bypass cell, so a stray code keeps the
	// chain length predictable instead of leaving the path undefined.
	always_comb begin
		sel_bnd = (st_r.ir == SBST_INS_EXTEST) || (st_r.ir == SBST_INS_HIZ_SAMP) ||
			(st_r.ir == SBST_INS_SAMPLE);
		sel_id  = (st_r.ir == SBST_INS_IDCODE);
	end

	always_comb begin
		st_nxt     = st_r;
		st_nxt.tap = tap_step(st_r.tap, tms);
		case (st_r.tap)
			SBST_TLR: begin
				st_nxt.ir = SBST_INS_IDCODE;
			end
			SBST_CAP_IR: begin
				st_nxt.ir_sh = SBST_IR_CAPTURE;
			end
			SBST_SH_IR: begin
				st_nxt.ir_sh = {tdi, st_r.ir_sh[SBST_IR_W-1:1]};
			end
			SBST_UPD_IR: begin
				st_nxt.ir = st_r.ir_sh;
			end
			SBST_CAP_DR: begin
				if (sel_bnd) begin
					st_nxt.bnd_sh = ring_sync;
					st_nxt.bnd_sh[SBST_CELL_INTERNAL] = 1'b0;
				end else if (sel_id) begin
					st_nxt.id_sh = ID_WORD;
				end else begin
					st_nxt.byp = SBST_BYP_CAPTURE;
				end
			end
			SBST_SH_DR: begin
				if (sel_bnd) begin
					st_nxt.bnd_sh = {tdi, st_r.bnd_sh[SBST_BND_LEN-1:1]};
				end else if (sel_id) begin
					st_nxt.id_sh = {tdi, st_r.id_sh[SBST_ID_W-1:1]};
				end else begin
					st_nxt.byp = tdi;
				end
			end
			SBST_UPD_DR: begin
				if (sel_bnd) begin
					st_nxt.hold = st_r.bnd_sh;
				end
			end
			default: begin
			end
		endcase
		st_nxt.hiz = (st_nxt.ir == SBST_INS_EXTEST) || (st_nxt.ir == SBST_INS_HIZ_SAMP);
		if (tck_rst) begin
			st_nxt     = '0;
			st_nxt.tap = SBST_TLR;
			st_nxt.ir  = SBST_INS_IDCODE;
		end
	end

	always_ff @(posedge tck) begin
		st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// Serial output
	// ----------------------------------------------------------------
	always_comb begin
		if (st_r.tap == SBST_SH_IR) begin
			tdo = st_r.ir_sh[0];
		end else if (sel_bnd) begin
			tdo = st_r.bnd_sh[0];
		end else if (sel_id) begin
			tdo = st_r.id_sh[0];
		end else begin
			tdo = st_r.byp;
		end
	end

	assign tdo_oe    = (st_r.tap == SBST_SH_DR) || (st_r.tap == SBST_SH_IR);
	assign ring_hold = st_r.hold;
	assign instr     = st_r.ir;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_id_rev;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_CAP_DR && sel_id) |=>
			st_r.id_sh[SBST_ID_REV_LSB +: SBST_ID_REV_W] == REV_CODE;
	endproperty
	a_id_rev: assert property (p_id_rev) else $error("revision field wrong");

	property p_id_depth;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_CAP_DR && sel_id) |=>
			st_r.id_sh[SBST_ID_DEPTH_LSB +: SBST_ID_DEPTH_W] == DEPTH_CODE;
	endproperty
	a_id_depth: assert property (p_id_depth) else $error("depth field wrong");

	property p_id_type;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_CAP_DR && sel_id) |=>
			st_r.id_sh[SBST_ID_TYPE_LSB +: SBST_ID_TYPE_W] == TYPE_CODE;
	endproperty
	a_id_type: assert property (p_id_type) else $error("type field wrong");

	property p_id_part;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_CAP_DR && sel_id) |=>
			st_r.id_sh[SBST_ID_PART_LSB +: SBST_ID_PART_W] ==
			(WIDE_ORG ? PART_WIDE : PART_NARROW);
	endproperty
	a_id_part: assert property (p_id_part) else $error("part field wrong");

	property p_id_maker;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_CAP_DR && sel_id) |=>
			st_r.id_sh[SBST_ID_MAKER_LSB +: SBST_ID_MAKER_W] == MAKER_CODE;
	endproperty
	a_id_maker: assert property (p_id_maker) else $error("maker field wrong");

	property p_id_present;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_CAP_DR && sel_id) ##1 (st_r.tap == SBST_SH_DR) |->
			tdo == SBST_ID_PRESENT_VAL;
	endproperty
	a_id_present: assert property (p_id_present) else $error("presence bit not one");

	property p_extest_hiz;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_UPD_IR && st_r.ir_sh == SBST_INS_EXTEST) |=> st_r.hiz && sel_bnd;
	endproperty
	a_extest_hiz: assert property (p_extest_hiz) else $error("extest not floating");

	property p_idcode_run;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_UPD_IR && st_r.ir_sh == SBST_INS_IDCODE) |=> !st_r.hiz && sel_id;
	endproperty
	a_idcode_run: assert property (p_idcode_run) else $error("idcode disturbs memory");

	property p_hizsamp;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_UPD_IR && st_r.ir_sh == SBST_INS_HIZ_SAMP) |=> st_r.hiz && sel_bnd;
	endproperty
	a_hizsamp: assert property (p_hizsamp) else $error("hiz sample not floating");

	property p_sample_run;
		@(posedge tck) disable iff (tck_rst)
		(st_r.ir == SBST_INS_SAMPLE) |-> !st_r.hiz && sel_bnd;
	endproperty
	a_sample_run: assert property (p_sample_run) else $error("sample disturbs memory");

	property p_bypass;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_SH_DR && st_r.ir == SBST_INS_BYPASS) |=> tdo == $past(tdi);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not one cell");

	property p_capture_ring;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_CAP_DR && sel_bnd) |=>
			st_r.bnd_sh[SBST_CELL_INTERNAL] == 1'b0 &&
			st_r.bnd_sh[SBST_CELL_ADDR1:SBST_CELL_CLOCK] ==
			$past(ring_sync[SBST_CELL_ADDR1:SBST_CELL_CLOCK]);
	endproperty
	a_capture_ring: assert property (p_capture_ring) else $error("ring capture wrong");

	property p_tlr_idcode;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_TLR) |=> st_r.ir == SBST_INS_IDCODE;
	endproperty
	a_tlr_idcode: assert property (p_tlr_idcode) else $error("reset lost idcode");

	property p_shift_only;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap != SBST_SH_DR && st_r.tap != SBST_CAP_DR) |=>
			$stable(st_r.bnd_sh) && $stable(st_r.id_sh);
	endproperty
	a_shift_only: assert property (p_shift_only) else $error("shift outside shift-dr");

	property p_lsb_first;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_SH_DR && sel_bnd) |=>
			st_r.bnd_sh[SBST_BND_LEN-1] == $past(tdi) &&
			st_r.bnd_sh[SBST_BND_LEN-2:0] == $past(st_r.bnd_sh[SBST_BND_LEN-1:1]);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("shift order wrong");

	property p_ir_capture;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_CAP_IR) |=> st_r.ir_sh[1:0] == SBST_IR_CAP_LOW;
	endproperty
	a_ir_capture: assert property (p_ir_capture) else $error("ir capture pattern wrong");

	property p_cv_idshift;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_SH_DR && sel_id);
	endproperty
	c_cv_idshift: cover property (p_cv_idshift);

	property p_cv_bypass;
		@(posedge tck) disable iff (tck_rst)
		(st_r.tap == SBST_SH_DR && st_r.ir == SBST_INS_BYPASS);
	endproperty
	c_cv_bypass: cover property (p_cv_bypass);

	property p_cv_hiz;
		@(posedge clk) disable iff (rst)
		mem_out_hiz;
	endproperty
	c_cv_hiz: cover property (p_cv_hiz);

endmodule : sbst_tap_regs
`default_nettype wire

// file: sbst_ctl_model.sv
// Behavioural test controller that drives the scan port from the far side.
`timescale 1ns/1ns
`default_nettype none
module sbst_ctl_model (
	output logic      tck,    // Test clock, still between frames.
	output logic      tms,    // Mode select.
	output logic      tdi,    // Serial data toward the device.
	input  wire logic tdo,    // Serial data from the device.
	input  wire logic tdo_oe  // Device drive enable of tdo.
);
	// ----------------------------------------------------------------
	// One test clock period of 125 ns
	// ----------------------------------------------------------------
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// Levels change only while tck is low, and tdo is taken just before the rise.
	task automatic step(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#62;
		q   = tdo;
		tck = 1'b1;
		#63;
		tck = 1'b0;
	endtask : step

	// Five rises with tms high reach reset from any state, then park in idle.
	task automatic tap_reset();
		logic q;
		repeat (5) step(1'b1, tdi, q);
		step(1'b0, tdi, q);
	endtask : tap_reset

	// ----------------------------------------------------------------
	// Scan from idle back to idle, least significant bit first
	// ----------------------------------------------------------------
	task automatic scan(input logic ir, input int n, input logic [127:0] din,
		output logic [127:0] dout, output logic oe_all);
		logic q;
		dout   = '0;
		oe_all = 1'b1;
		step(1'b1, tdi, q);
		if (ir) begin
			step(1'b1, tdi, q);
		end
		step(1'b0, tdi, q);
		step(1'b0, tdi, q);
		for (int i = 0; i < n; i++) begin
			oe_all &= tdo_oe;
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		// Once shifting ends tdi carries no meaning, so it shows the inverse level.
		step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask : scan
endmodule : sbst_ctl_model
`default_nettype wire

// file: sbst_tap_regs_tb_top.sv
// Self-checking testbench of the scan-register block.
`timescale 1ns/1ns
`default_nettype none
module sbst_tap_regs_tb_top;
	import sbst_pkg::*;
	logic                      clk;
	logic                      rst;
	logic                      tck;
	logic                      tms;
	logic                      tdi;
	logic                      tdo;
	logic                      tdo_oe;
	logic                      mem_out_hiz;
	logic [SBST_BND_LEN-1:0]   ring_in;
	logic [SBST_BND_LEN-1:0]   ring_hold;
	logic [SBST_IR_W-1:0]      instr;
	logic [127:0]              dout;
	logic [127:0]              exp_v;
	logic                      oe_all;
	int                        n_errors = 0;
	int                        checks_done = 0;
	localparam logic [SBST_BND_LEN-1:0] PATS [3] = '{71'h40_0000_0030_0004_007f,
		71'h3f_ffff_ffcf_fffb_ff80, 71'h2a_5555_aaaa_0f0f_3c3c};
	localparam logic [SBST_IR_W-1:0] CODES [3] = '{SBST_INS_HIZ_SAMP, SBST_INS_SAMPLE,
		SBST_INS_EXTEST};
	localparam logic HIZ_EXP [3] = '{1'b1, 1'b0, 1'b1};

	// ----------------------------------------------------------------
	// Clock, device and far-side controller
	// ----------------------------------------------------------------
	initial clk = 1'b0;
	always #20 clk = ~clk;

	// The narrow organisation is built here so that its part code is the one read back.
	sbst_tap_regs #(
		.WIDE_ORG    (1'b0),
		.REV_CODE    (3'h5),   // Arbitrary value.
		.DEPTH_CODE  (5'h13),  // Arbitrary value.
		.PART_NARROW (6'h15),  // Arbitrary value.
		.MAKER_CODE  (11'h2c3) // Arbitrary value.
	) dut_u (
		.clk         (clk),
		.rst         (rst),
		.tck         (tck),
		.tms         (tms),
		.tdi         (tdi),
		.tdo         (tdo),
		.tdo_oe      (tdo_oe),
		.ring_in     (ring_in),
		.ring_hold   (ring_hold),
		.instr       (instr),
		.mem_out_hiz (mem_out_hiz)
	);

	sbst_ctl_model ctl_u (
		.tck    (tck),
		.tms    (tms),
		.tdi    (tdi),
		.tdo    (tdo),
		.tdo_oe (tdo_oe)
	);

	// ----------------------------------------------------------------
	// Comparison and closing
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		#200000;
		n_errors++;
		$display("MISMATCH watchdog expected done seen hang");
		finish_test();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		rst     = 1'b1;
		ring_in = '0;
		// The reset reaches the test side through tck flops, so tck runs while it is held.
		repeat (6) @(negedge clk);
		ctl_u.tap_reset();
		@(negedge clk);
		rst = 1'b0;
		ctl_u.tap_reset();
		check("instr after reset", instr, SBST_INS_IDCODE);
		check("tdo_oe idle", tdo_oe, 1'b0);

		// Shifting twice the identity length shows the shifted-in word after exactly 32 cells.
		ctl_u.scan(1'b0, 64, {96'h0, 32'hc3a5_5a3c}, dout, oe_all);
		check("id revision", dout[31:29], 3'h5);
		check("id depth", dout[28:24], 5'h13);
		check("id type", dout[23:18], 6'h2d);
		check("id part", dout[17:12], 6'h15);
		check("id maker", dout[11:1], 11'h2c3);
		check("id present", dout[0], SBST_ID_PRESENT_VAL);
		check("id only 32 bits", dout[127:32], {64'h0, 32'hc3a5_5a3c});
		check("tdo_oe in shift", oe_all, 1'b1);
		check("hiz under identity", mem_out_hiz, 1'b0);
		$display("test identity done");

		ctl_u.scan(1'b1, 3, {125'h0, SBST_INS_BYPASS}, dout, oe_all);
		check("ir capture", dout[1:0], SBST_IR_CAP_LOW);
		check("instr bypass", instr, SBST_INS_BYPASS);
		ctl_u.scan(1'b0, 4, 128'h5, dout, oe_all);
		check("bypass path", dout[3:0], 4'ha);
		check("hiz under bypass", mem_out_hiz, 1'b0);
		$display("test bypass done");

		for (int k = 0; k < 3; k++) begin
			@(negedge clk);
			ring_in = PATS[k];
			ctl_u.scan(1'b1, 3, {125'h0, CODES[k]}, dout, oe_all);
			repeat (5) @(negedge clk);
			check("instr boundary", instr, CODES[k]);
			check("mem_out_hiz", mem_out_hiz, HIZ_EXP[k]);
			ctl_u.scan(1'b0, SBST_BND_LEN, {57'h0, ~PATS[k]}, dout, oe_all);
			exp_v = {57'h0, PATS[k]};
			exp_v[SBST_CELL_INTERNAL] = 1'b0;
			check("ring capture", dout, exp_v);
			check("ring hold", ring_hold, {57'h0, ~PATS[k]});
			check("tdo_oe in shift", oe_all, 1'b1);
			$display("test boundary code %0d done", k);
		end

		// A mode-select reset must leave the test mode and release the memory outputs.
		ctl_u.tap_reset();
		check("instr after tlr", instr, SBST_INS_IDCODE);
		repeat (5) @(negedge clk);
		check("hiz after tlr", mem_out_hiz, 1'b0);
		$display("test logic reset done");
		finish_test();
	end
endmodule : sbst_tap_regs_tb_top
`default_nettype wire
